// >>> hdl/aslf_lane_framer.v
// Serial lane framer for a 14-bit converter output.
// Behaviour
// RULE_01 - Pad 14-bit result with four low zeros; the code pads two (ASLF_PAD 2'h0, 16-bit word).
// RULE_02 - Upper octet high bits, lower octet plus zeros.
// RULE_03 - Single lane serial octets, or dual lanes.
// RULE_04 - Single-lane mode is the reset default.
// RULE_05 - Receiver pulls request low for realignment.
// RULE_06 - Send K28.5 while request is asserted.
// RULE_07 - K28.5 starts nine clocks after falling edge.
// RULE_08 - Request latched on lagging internal clock.
// RULE_09 - Data resumes eight clocks after rising edge.
// RULE_10 - Dual lane: upper on lane one, lower lane two.
`timescale 1ns/1ps
`include "aslf_defs.vh"
module aslf_lane_framer (
  input wire clk_sys_i,
  input wire reset_i,
  input wire [`ASLF_RES_W-1:0] sample_i,
  input wire dual_lane_i,
  input wire sync_n_i,
  output reg [7:0] lane0_data_o,
  output reg lane0_k_o,
  output reg [7:0] lane1_data_o,
  output reg lane1_k_o,
  output reg lane1_valid_o,
  output reg octet_phase_o
);
  reg [`ASLF_WORD_W-1:0] word_q;
  reg dual_q;
  reg phase_q;
  reg busy_q;
  reg sync_q;
  reg sending_k_q;
  reg [`ASLF_LAT_W-1:0] cnt_q;
  wire sync_lat;
  wire [`ASLF_WORD_W-1:0] word_d;
  wire [7:0] hi_octet;
  wire [7:0] lo_octet;
  localparam [31:0] ACT_LOAD = `ASLF_ACT_LAT - `ASLF_LAG_CYC - `ASLF_FIXED_STAGES;
  localparam [31:0] DEACT_LOAD = `ASLF_DEACT_LAT - `ASLF_LAG_CYC - `ASLF_FIXED_STAGES;

  function [`ASLF_LAT_W-1:0] lat_dec;
    input [`ASLF_LAT_W-1:0] v;
    begin
      lat_dec = (v == `ASLF_ZERO) ? `ASLF_ZERO : v - `ASLF_ONE;
    end
  endfunction

  // Pads the result to the 16-bit word with zero bits below the LSB.
  assign word_d = {sample_i, `ASLF_PAD}; // see RULE_01
  assign hi_octet = word_q[`ASLF_WORD_W-1:8]; // see RULE_02
  assign lo_octet = word_q[7:0]; // see RULE_02

  // Models the lagging internal latch clock as a whole-cycle delay.
  aslf_lat_delay #(
    .DEPTH(`ASLF_LAG_CYC)
  ) u_lag (
    .clk_sys_i(clk_sys_i),
    .reset_i(reset_i),
    .d_i(~sync_n_i),
    .init_i(reset_i),
    .q_o(sync_lat)
  ); // see RULE_08

  // Counts latency from a detected request edge to the output switch.
  always @(posedge clk_sys_i) begin
    if (reset_i) begin
      dual_q <= 1'b0; // see RULE_04
      word_q <= {`ASLF_WORD_W{1'b0}};
      phase_q <= 1'b0;
      sync_q <= 1'b0;
      sending_k_q <= 1'b0;
      cnt_q <= `ASLF_ZERO;
      busy_q <= 1'b0;
    end else begin
      dual_q <= dual_lane_i;
      phase_q <= dual_q ? 1'b0 : ~phase_q; // see RULE_03
      if (dual_q || phase_q) begin
        word_q <= word_d;
      end
      if (sync_lat != sync_q) begin
        // A new edge restarts the count; the load leaves room for the lag and output stage.
        sync_q <= sync_lat;
        cnt_q <= sync_lat ? ACT_LOAD[`ASLF_LAT_W-1:0]
                          : DEACT_LOAD[`ASLF_LAT_W-1:0]; // see RULE_07 see RULE_09
        busy_q <= 1'b1;
      end else if (busy_q) begin
        cnt_q <= lat_dec(cnt_q);
        if (cnt_q == `ASLF_ZERO) begin
          sending_k_q <= sync_q; // see RULE_06
          busy_q <= 1'b0;
        end
      end
    end
  end

  // Drives octets or K28.5 on the lanes.
  always @(posedge clk_sys_i) begin
    if (reset_i) begin
      lane0_data_o <= 8'h00;
      lane0_k_o <= 1'b0;
      lane1_data_o <= 8'h00;
      lane1_k_o <= 1'b0;
      lane1_valid_o <= 1'b0;
      octet_phase_o <= 1'b0;
    end else begin
      lane1_valid_o <= dual_q;
      octet_phase_o <= phase_q;
      if (sending_k_q) begin
        lane0_data_o <= `ASLF_K28_5; // see RULE_06
        lane0_k_o <= 1'b1;
        lane1_data_o <= dual_q ? `ASLF_K28_5 : 8'h00;
        lane1_k_o <= dual_q;
      end else if (dual_q) begin
        lane0_data_o <= hi_octet; // see RULE_10
        lane0_k_o <= 1'b0;
        lane1_data_o <= lo_octet; // see RULE_10
        lane1_k_o <= 1'b0;
      end else begin
        lane0_data_o <= phase_q ? lo_octet : hi_octet; // see RULE_03
        lane0_k_o <= 1'b0;
        lane1_data_o <= 8'h00;
        lane1_k_o <= 1'b0;
      end
    end
  end
endmodule

// >>> shared/aslf_defs.vh
// Constants for the converter serial lane framer.
`ifndef ASLF_DEFS_VH
`define ASLF_DEFS_VH
`define ASLF_RES_W 14
`define ASLF_WORD_W 16
`define ASLF_PAD 2'h0
`define ASLF_K28_5 8'hBC
`define ASLF_CLK_PERIOD_NS 10
`define ASLF_LAG_PS 10500
`define ASLF_LAG_CYC (((`ASLF_LAG_PS) + (`ASLF_CLK_PERIOD_NS * 1000) - 1) / (`ASLF_CLK_PERIOD_NS * 1000))
`define ASLF_ACT_LAT 9
`define ASLF_DEACT_LAT 8
`define ASLF_FIXED_STAGES 2
`define ASLF_LAT_W 4
`define ASLF_ONE 4'h1
`define ASLF_ZERO 4'h0
`endif

// >>> hdl/aslf_lat_delay.v
// Delay line that holds a level for a fixed number of clocks.
`timescale 1ns/1ps
module aslf_lat_delay #(
  parameter DEPTH = 2
) (
  input wire clk_sys_i,
  input wire reset_i,
  input wire d_i,
  input wire init_i,
  output wire q_o
);
  reg [DEPTH-1:0] pipe_q;
  // Shifts the level one stage each clock; reset loads the idle level.
  always @(posedge clk_sys_i) begin
    if (reset_i) begin
      pipe_q <= {DEPTH{1'b0}};
    end else begin
      pipe_q <= {pipe_q[DEPTH-2:0], d_i};
    end
  end
  assign q_o = init_i ? 1'b0 : pipe_q[DEPTH-1];
endmodule

// >>> test/aslf_rx_model.sv
// Receiver model that drives the frame alignment request.
`timescale 1ns/1ps
module aslf_rx_model (input wire clk_sys_i, input wire reset_i, input wire realign_i,
  output reg sync_n_o);
  always @(posedge clk_sys_i) sync_n_o <= reset_i | !realign_i;
endmodule

// >>> test/aslf_lane_monitor.sv
// Assertions on the lane framer ports.
`timescale 1ns/1ps
module aslf_monitor (
  input wire clk_sys_i, reset_i, sync_n_i, lane0_k_o, lane1_k_o, lane1_valid_o, octet_phase_o,
  input wire [7:0] lane0_data_o, lane1_data_o
);
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (reset_i);
  sequence fall_s; $fell(sync_n_i); endsequence
  sequence rise_s; $rose(sync_n_i); endsequence
  k_go_a: assert property (fall_s |-> ##[9:10] lane0_k_o)
    else $error("late K");
  k_early_a: assert property (fall_s |-> (!lane0_k_o) [*8])
    else $error("early K");
  k_stop_a: assert property (rise_s |-> ##[8:9] !lane0_k_o)
    else $error("late data");
  k_hold_a: assert property (rise_s |-> lane0_k_o [*8])
    else $error("early data");
  k_char_a: assert property (lane0_k_o |-> lane0_data_o == 8'hBC)
    else $error("bad K");
  k_dual_a: assert property (lane1_k_o |-> lane0_k_o && lane1_data_o == 8'hBC)
    else $error("bad K");
  pad_lo_a: assert property
    (octet_phase_o && !lane0_k_o |-> lane0_data_o[1:0] == 2'h0) else $error("pad");
  pad_dual_a: assert property
    (lane1_valid_o && !lane1_k_o |-> lane1_data_o[1:0] == 2'h0) else $error("pad");
  dual_ph_a: assert property (lane1_valid_o |-> !octet_phase_o)
    else $error("phase");
  mode_rst_a: assert property (disable iff (1'b0) reset_i |=> !lane1_valid_o)
    else $error("mode");
endmodule
bind aslf_lane_framer aslf_monitor mon_u (.*);

// >>> test/test_aslf_lane_framer.sv
// Self-checking bench for the serial lane framer.
`timescale 1ns/1ps
module test_aslf_lane_framer;
  reg clk_sys_i = 1'b0, reset_i = 1'b1, dual_lane_i = 1'b0, realign = 1'b0;
  reg [13:0] sample_i = 14'h3A5C;
  wire sync_n_i, lane0_k_o, lane1_k_o, lane1_valid_o, octet_phase_o;
  wire [7:0] lane0_data_o, lane1_data_o;
  wire [15:0] word = {sample_i, 2'h0};
  integer n_errors = 0, compares = 0, i;
  aslf_rx_model rx_u (.clk_sys_i, .reset_i, .realign_i(realign), .sync_n_o(sync_n_i));
  aslf_lane_framer dut_u (.*);
  initial forever #5 clk_sys_i = ~clk_sys_i;
  task chk(input [15:0] seen, input [15:0] exp);
    compares = compares + 1;
    if (seen !== exp) begin
      n_errors = n_errors + 1;
      $display("[FAIL] %0t %h %h", $time, seen, exp);
    end
  endtask
  task tick(input integer n);
    repeat (n) @(posedge clk_sys_i);
    #1;
  endtask
  task t_single;
    reg ph;
    reg [8:0] exp9;
    begin
      chk({lane1_valid_o, lane1_data_o}, 9'h000);
      ph = octet_phase_o;
      for (i = 0; i < 2; i = i + 1) begin
        exp9 = (ph ^ i[0]) ? {1'b1, word[7:0]} : {1'b0, word[15:8]};
        chk({octet_phase_o, lane0_data_o}, exp9);
        tick(1);
      end
    end
  endtask
  task t_dual;
    @(posedge clk_sys_i) dual_lane_i <= 1'b1;
    sample_i <= 14'h1F03;
    tick(4);
    chk({lane1_valid_o, octet_phase_o}, 2'h2);
    chk({lane0_data_o, lane1_data_o}, word);
  endtask
  task t_sync;
    @(posedge clk_sys_i) realign <= 1'b1;
    tick(10);
    chk(lane0_k_o, 1'b0);
    tick(1);
    chk({lane0_k_o, lane1_k_o, lane0_data_o}, 10'h3BC);
    @(posedge clk_sys_i) realign <= 1'b0;
    tick(9);
    chk(lane0_k_o, 1'b1);
    tick(1);
    chk({lane0_k_o, lane1_k_o, lane1_data_o}, {2'h0, word[7:0]});
  endtask
  task wrap_up;
    $display("compares %0d errors %0d", compares, n_errors);
    if (n_errors == 0 && compares > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  initial begin
    repeat (6) @(posedge clk_sys_i);
    reset_i <= 1'b0;
    tick(4);
    t_single;
    t_dual;
    t_sync;
    wrap_up;
  end
  initial begin
    repeat (500) @(posedge clk_sys_i);
    n_errors = n_errors + 1;
    wrap_up;
  end
endmodule
